// [design/pmc_regs.svh]
// register indices, field positions and reset values of the logic control register bank
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_IDX_IMC_A 10'h00A
`define PMC_IDX_IMC_B 10'h00B
`define PMC_IDX_IMC_C 10'h01A
`define PMC_IDX_CELL_A 10'h020
`define PMC_IDX_CELL_B 10'h021
`define PMC_IDX_MASK_A 10'h022
`define PMC_IDX_MASK_B 10'h023
`define PMC_IDX_LOCK_LO 10'h0C0
`define PMC_IDX_LOCK_HI 10'h0C1
`define PMC_IDX_BOOT 10'h0C2
`define PMC_IDX_SCAN 10'h0C7
`define PMC_IDX_PSC0 10'h0B0
`define PMC_IDX_PSC2 10'h0B4
`define PMC_IDX_PAGE 10'h0E0
`define PMC_IDX_MAP 10'h0E2
`define PMC_PSC0_AUTO_PD 1
`define PMC_PSC0_TURBO_OFF 3
`define PMC_PSC0_ARRAY_CLK 4
`define PMC_PSC0_CELL_CLK 5
`define PMC_PSC2_ADDR 0
`define PMC_PSC2_CTL_IN 2
`define PMC_PSC2_ALE 5
`define PMC_PSC2_HIGH_BYTE 6
`define PMC_MAP_PERIPH 7
`define PMC_WMASK_SCAN 8'h01
`define PMC_WMASK_PSC0 8'h3A
`define PMC_WMASK_PSC2 8'h7D
`define PMC_WMASK_MAP 8'h9F
`define PMC_RST_REG 8'h00
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`endif

// [design/pmc_pkg.sv]
// types shared by the logic control register bank
package pmc_pkg;
    typedef struct packed {
        logic [23:0] imc;
        logic [15:0] sector_lock;
        logic [3:0] boot_lock;
        logic security_set;
        logic reset_pin_n;
        logic [3:0] map_strap;
        logic [7:0] addr_low;
        logic [3:0] port_f_low_pins;
        logic [3:0] multiplexed_bus_upper_nibble;
        logic [2:0] control_inputs;
        logic ale;
        logic high_byte_write_enable;
        logic logic_clock_input;
        logic alt_bus_mode;
        logic mode_8051;
    } pmc_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [2:0] control_inputs;
        logic ale;
        logic high_byte_write_enable;
    } pmc_feed_t;

    // bit 4 read strobe primary, 3 read strobe secondary, 2..0 program strobe primary/secondary/sram
    typedef logic [4:0] pmc_access_t;

    typedef struct packed {
        pmc_pins_t sync1;
        pmc_pins_t sync2;
        logic clk_prev;
        logic aw_got;
        logic [9:0] aw_idx;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] cell_a;
        logic [7:0] cell_b;
        logic [7:0] mask_a;
        logic [7:0] mask_b;
        logic [7:0] scan;
        logic [7:0] page;
        logic [7:0] psc0;
        logic [7:0] psc2;
        logic [7:0] map;
        pmc_feed_t feed;
        logic array_clk;
        logic cell_clk;
        logic wake;
        logic fast;
        pmc_access_t access;
    } pmc_state_t;
endpackage

// [design/pmc_bank.sv]
// logic control register bank behind an AXI4-Lite slave
`timescale 1ns/1ns
`include "pmc_regs.svh"
module pmc_bank import pmc_pkg::*; #(
    parameter int AW = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pmc_pins_t pins_in,
    output pmc_feed_t array_feed,
    output logic [7:0] cell_bank_a,
    output logic [7:0] cell_bank_b,
    output logic [7:0] page_value_bit,
    output logic scan_port_enable,
    output logic automatic_power_down,
    output logic logic_fast_mode,
    output logic array_clock_out,
    output logic cell_clock_out,
    output logic logic_wake,
    output pmc_access_t strobe_access,
    output logic port_f_peripheral
);
    if (AW < 12) begin : g_aw_check
        $error("pmc_bank: AW must be at least 12");
    end

    pmc_state_t s_q;
    pmc_state_t s_d;
    pmc_pins_t p;
    logic wr_commit;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] rd_val;

    assign p = s_q.sync2;

    // ----------------------------------------------------------
    // read decode
    // ----------------------------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        rd_val = `PMC_RST_REG;
        case (araddr[11:2])
            `PMC_IDX_IMC_A: rd_val = p.imc[7:0];
            `PMC_IDX_IMC_B: rd_val = p.imc[15:8];
            `PMC_IDX_IMC_C: rd_val = p.imc[23:16];
            `PMC_IDX_CELL_A: rd_val = s_q.cell_a;
            `PMC_IDX_CELL_B: rd_val = s_q.cell_b;
            `PMC_IDX_MASK_A: rd_val = s_q.mask_a;
            `PMC_IDX_MASK_B: rd_val = s_q.mask_b;
            `PMC_IDX_LOCK_LO: rd_val = p.sector_lock[7:0];
            `PMC_IDX_LOCK_HI: rd_val = p.sector_lock[15:8];
            `PMC_IDX_BOOT: rd_val = {p.security_set, 3'h0, p.boot_lock};
            `PMC_IDX_SCAN: rd_val = s_q.scan;
            `PMC_IDX_PSC0: rd_val = s_q.psc0;
            `PMC_IDX_PSC2: rd_val = s_q.psc2;
            `PMC_IDX_PAGE: rd_val = s_q.page;
            `PMC_IDX_MAP: rd_val = s_q.map;
            default: rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb begin
        s_d = s_q;
        wr_commit = 1'b0;
        wr_hit = 1'b1;
        s_d.sync1 = pins_in;
        s_d.sync2 = s_q.sync1;
        // write address and data are taken in either order
        if (awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.aw_idx = awaddr[11:2];
        end
        if (wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.w_data = wdata[7:0];
            s_d.w_lane0 = wstrb[0];
        end
        if (s_q.aw_got && s_q.w_got) begin
            wr_commit = 1'b1;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
        end
        if (wr_commit && s_q.w_lane0) begin
            case (s_q.aw_idx)
                `PMC_IDX_CELL_A: s_d.cell_a = (s_q.cell_a & s_q.mask_a) | (s_q.w_data & ~s_q.mask_a);
                `PMC_IDX_CELL_B: s_d.cell_b = (s_q.cell_b & s_q.mask_b) | (s_q.w_data & ~s_q.mask_b);
                `PMC_IDX_MASK_A: s_d.mask_a = s_q.w_data;
                `PMC_IDX_MASK_B: s_d.mask_b = s_q.w_data;
                `PMC_IDX_SCAN: s_d.scan = s_q.w_data & `PMC_WMASK_SCAN;
                `PMC_IDX_PAGE: s_d.page = s_q.w_data;
                `PMC_IDX_PSC0: s_d.psc0 = s_q.w_data & `PMC_WMASK_PSC0;
                `PMC_IDX_PSC2: s_d.psc2 = s_q.w_data & `PMC_WMASK_PSC2;
                `PMC_IDX_MAP: s_d.map = s_q.w_data & `PMC_WMASK_MAP;
                `PMC_IDX_IMC_A, `PMC_IDX_IMC_B, `PMC_IDX_IMC_C,
                `PMC_IDX_LOCK_LO, `PMC_IDX_LOCK_HI, `PMC_IDX_BOOT: wr_hit = 1'b1;
                default: wr_hit = 1'b0;
            endcase
        end
        if (wr_commit) begin
            s_d.bresp = wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;
        // one read at a time, answered the cycle after the address
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = rd_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        s_d.arready = !s_d.rvalid;
        // reset pin wins over a write in the same cycle; power control keeps its value
        if (!p.reset_pin_n) begin
            s_d.cell_a = `PMC_RST_REG;
            s_d.cell_b = `PMC_RST_REG;
            s_d.mask_a = `PMC_RST_REG;
            s_d.mask_b = `PMC_RST_REG;
            s_d.scan = `PMC_RST_REG;
            s_d.page = `PMC_RST_REG;
            s_d.map = {3'h0, p.map_strap, 1'b0};
        end
        // logic array feeds
        if (s_q.psc2[`PMC_PSC2_ADDR]) begin
            s_d.feed.addr = 8'h00;
        end else if (p.alt_bus_mode) begin
            s_d.feed.addr = {p.multiplexed_bus_upper_nibble, p.port_f_low_pins};
        end else begin
            s_d.feed.addr = p.addr_low;
        end
        s_d.feed.control_inputs = p.control_inputs & ~s_q.psc2[`PMC_PSC2_CTL_IN+:3];
        s_d.feed.ale = p.ale & ~s_q.psc2[`PMC_PSC2_ALE];
        s_d.feed.high_byte_write_enable = p.high_byte_write_enable & ~s_q.psc2[`PMC_PSC2_HIGH_BYTE];
        // logic clock gating and wake on each clock change in slow mode while the array clock is not gated
        s_d.clk_prev = p.logic_clock_input;
        s_d.array_clk = p.logic_clock_input & ~s_q.psc0[`PMC_PSC0_ARRAY_CLK];
        s_d.cell_clk = p.logic_clock_input & ~s_q.psc0[`PMC_PSC0_CELL_CLK];
        s_d.wake = (p.logic_clock_input ^ s_q.clk_prev) & s_q.psc0[`PMC_PSC0_TURBO_OFF]
            & ~s_q.psc0[`PMC_PSC0_ARRAY_CLK];
        s_d.fast = ~s_q.psc0[`PMC_PSC0_TURBO_OFF];
        s_d.access = p.mode_8051 ? s_q.map[4:0] : 5'h00;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rdata = {24'h000000, s_q.rdata};
    assign rresp = s_q.rresp;
    assign array_feed = s_q.feed;
    assign cell_bank_a = s_q.cell_a;
    assign cell_bank_b = s_q.cell_b;
    assign page_value_bit = s_q.page;
    assign scan_port_enable = s_q.scan[0];
    assign automatic_power_down = s_q.psc0[`PMC_PSC0_AUTO_PD];
    assign logic_fast_mode = s_q.fast;
    assign array_clock_out = s_q.array_clk;
    assign cell_clock_out = s_q.cell_clk;
    assign logic_wake = s_q.wake;
    assign strobe_access = s_q.access;
    assign port_f_peripheral = s_q.map[`PMC_MAP_PERIPH];

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rd_at(logic [9:0] idx);
        arvalid && arready && araddr[11:2] == idx;
    endsequence

    sequence wr_at(logic [9:0] idx);
        wr_commit && s_q.w_lane0 && s_q.aw_idx == idx && p.reset_pin_n;
    endsequence

    chk_imc_read: assert property (rd_at(`PMC_IDX_IMC_C) |=> rvalid && rdata[7:0] == $past(p.imc[23:16]))
        else $error("input cell read wrong");
    chk_cell_load: assert property (wr_at(`PMC_IDX_CELL_A) |=> cell_bank_a ==
        (($past(s_q.cell_a) & $past(s_q.mask_a)) | ($past(s_q.w_data) & ~$past(s_q.mask_a))))
        else $error("masked cell load wrong");
    chk_cell_readback: assert property (rd_at(`PMC_IDX_CELL_B) |=> rdata[7:0] == $past(cell_bank_b))
        else $error("cell bank b read wrong");
    chk_lock_read: assert property (rd_at(`PMC_IDX_LOCK_HI) |=> rdata[7:0] == $past(p.sector_lock[15:8]))
        else $error("sector lock read wrong");
    chk_boot_read: assert property (rd_at(`PMC_IDX_BOOT)
        |=> rdata[6:4] == 3'h0 && rdata[7] == $past(p.security_set) && rdata[3:0] == $past(p.boot_lock))
        else $error("boot lock read wrong");
    chk_scan_write: assert property (wr_at(`PMC_IDX_SCAN) |=> scan_port_enable == $past(s_q.w_data[0]))
        else $error("scan gate not loaded");
    chk_page_pin: assert property (!p.reset_pin_n |=> page_value_bit == 8'h00)
        else $error("page not cleared");
    chk_psc0_keep: assert property (!p.reset_pin_n && !wr_commit |=> $stable(s_q.psc0))
        else $error("power control 0 changed by reset pin");
    chk_auto_pd: assert property (wr_at(`PMC_IDX_PSC0) |=> automatic_power_down == $past(s_q.w_data[1]))
        else $error("power-down enable wrong");
    chk_fast_mode: assert property (s_q.psc0[3] && $stable(s_q.psc0) |=> !logic_fast_mode)
        else $error("fast mode not off");
    chk_wake_edge: assert property ($changed(p.logic_clock_input) && s_q.psc0[3] && !s_q.psc0[4]
        |=> logic_wake)
        else $error("wake pulse missing");
    chk_cell_clk: assert property (s_q.psc0[5] |=> !cell_clock_out)
        else $error("cell clock not gated");
    chk_addr_gate: assert property (s_q.psc2[0] |=> array_feed.addr == 8'h00)
        else $error("address not blocked");
    chk_alt_addr: assert property (!s_q.psc2[0] && p.alt_bus_mode
        |=> array_feed.addr == {$past(p.multiplexed_bus_upper_nibble), $past(p.port_f_low_pins)})
        else $error("alternate address source wrong");
    chk_ctl_gate: assert property (s_q.psc2[6:2] == 5'h1F |=> array_feed.control_inputs == 3'h0
        && !array_feed.ale && !array_feed.high_byte_write_enable)
        else $error("control inputs not blocked");
    chk_map_reset: assert property (!p.reset_pin_n |=> s_q.map == {3'h0, $past(p.map_strap), 1'b0})
        else $error("memory map reset wrong");
    chk_map_mode: assert property (!p.mode_8051 |=> strobe_access == 5'h00)
        else $error("map active outside 8051 mode");
    chk_map_use: assert property (p.mode_8051 |=> strobe_access == $past(s_q.map[4:0]))
        else $error("strobe access wrong");
    chk_periph: assert property (wr_at(`PMC_IDX_MAP) |=> port_f_peripheral == $past(s_q.w_data[7]))
        else $error("peripheral mode wrong");
    chk_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    chk_imc_low: assert property (rd_at(`PMC_IDX_IMC_A) |=> rdata[7:0] == $past(p.imc[7:0]))
        else $error("input cell low read wrong");
    chk_cell_a_read: assert property (rd_at(`PMC_IDX_CELL_A) |=> rdata[7:0] == $past(cell_bank_a))
        else $error("cell bank a read wrong");
    chk_mask_hold: assert property (wr_at(`PMC_IDX_CELL_B) |=>
        (cell_bank_b & $past(s_q.mask_b)) == ($past(cell_bank_b) & $past(s_q.mask_b)))
        else $error("masked cell changed");
    chk_cell_b_load: assert property (wr_at(`PMC_IDX_CELL_B) |=>
        (cell_bank_b & ~$past(s_q.mask_b)) == ($past(s_q.w_data) & ~$past(s_q.mask_b)))
        else $error("unmasked cell not loaded");
    chk_lock_low: assert property (rd_at(`PMC_IDX_LOCK_LO) |=> rdata[7:0] == $past(p.sector_lock[7:0]))
        else $error("low sector lock read wrong");
    chk_page_write: assert property (wr_at(`PMC_IDX_PAGE) |=> page_value_bit == $past(s_q.w_data))
        else $error("page not loaded");
    chk_fast_on: assert property (!s_q.psc0[3] |=> logic_fast_mode)
        else $error("fast mode not on");
    chk_array_gate: assert property (s_q.psc0[4] |=> !array_clock_out)
        else $error("array clock not gated");
    chk_wake_quiet: assert property (s_q.psc0[4] || !s_q.psc0[3] |=> !logic_wake)
        else $error("wake pulse while not allowed");
    chk_cell_pass: assert property (!s_q.psc0[5] |=> cell_clock_out == $past(p.logic_clock_input))
        else $error("cell clock not passed");
    chk_addr_pass: assert property (!s_q.psc2[0] && !p.alt_bus_mode |=> array_feed.addr == $past(p.addr_low))
        else $error("address not passed");
    chk_ctl_two: assert property (s_q.psc2[4] |=> !array_feed.control_inputs[2])
        else $error("control input two not blocked");
    chk_ctl_pass: assert property (s_q.psc2[4:2] == 3'h0 |=> array_feed.control_inputs == $past(p.control_inputs))
        else $error("control inputs not passed");
    chk_ale_pass: assert property (!s_q.psc2[5] |=> array_feed.ale == $past(p.ale))
        else $error("ale not passed");
    chk_map_clear: assert property (!p.reset_pin_n |=> !port_f_peripheral)
        else $error("peripheral mode not cleared");

    // ----------------------------------------------------------
    // bus handshake checks
    // ----------------------------------------------------------
    sequence aw_take;
        awvalid && awready;
    endsequence

    sequence w_take;
        wvalid && wready;
    endsequence

    sequence rd_miss;
        arvalid && arready && !rd_hit;
    endsequence

    chk_aw_closed: assert property (aw_take |=> !awready)
        else $error("write address accepted twice");
    chk_w_closed: assert property (w_take |=> !wready)
        else $error("write data accepted twice");
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
    chk_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write channel not reopened");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response not held");
    chk_r_release: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read channel not reopened");
    chk_rd_refuse: assert property (rd_miss |=> rresp == `PMC_RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not refused");
endmodule

// [tb/pmc_pin_model.sv]
// pin-side logic model that feeds the device pins
`timescale 1ns/1ns
module pmc_pin_model import pmc_pkg::*; (
    input wire logic aclk,
    input wire pmc_pins_t pins_set,
    input wire logic run_clk,
    output pmc_pins_t pins
);
    logic [1:0] div_q = 2'h0;
    logic clk_q = 1'b0;
    always_ff @(posedge aclk) begin
        div_q <= div_q + 2'h1;
        if (!run_clk) begin
            clk_q <= 1'b0; // clock input stands still outside bursts
        end else if (div_q == 2'h3) begin
            clk_q <= ~clk_q; // every edge is a wake source for slow logic while the array clock is not gated
        end
    end
    always_comb begin
        pins = pins_set;
        pins.logic_clock_input = clk_q;
    end
endmodule

// [tb/testbench.sv]
// self-checking bench for the logic control register bank
`timescale 1ns/1ns
`include "pmc_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench import pmc_pkg::*;;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [1:0] OK = `PMC_RESP_OKAY;
    localparam logic [1:0] ERR = `PMC_RESP_SLVERR;
    localparam logic [9:0] RW_IDX [9] = '{`PMC_IDX_CELL_A, `PMC_IDX_CELL_B, `PMC_IDX_MASK_A, `PMC_IDX_MASK_B,
        `PMC_IDX_SCAN, `PMC_IDX_PAGE, `PMC_IDX_PSC0, `PMC_IDX_PSC2, `PMC_IDX_MAP};
    localparam logic [7:0] RW_BACK [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'h3A, 8'h7D, 8'h9F};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, run_clk = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, scan_en, auto_pd, fast, arr_clk, cel_clk, wake, pf_per;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] cell_a, cell_b, page;
    pmc_feed_t feed;
    pmc_access_t acc;
    pmc_pins_t pset, pins;
    int n_errors = 0;
    int n_compared = 0;
    int w, a, c;

    always #5 aclk = ~aclk;

    pmc_pin_model i_pins (.aclk(aclk), .pins_set(pset), .run_clk(run_clk), .pins(pins));

    pmc_bank #(.AW(12)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins_in(pins), .array_feed(feed),
        .cell_bank_a(cell_a), .cell_bank_b(cell_b), .page_value_bit(page), .scan_port_enable(scan_en),
        .automatic_power_down(auto_pd), .logic_fast_mode(fast), .array_clock_out(arr_clk),
        .cell_clock_out(cel_clk), .logic_wake(wake), .strobe_access(acc), .port_f_peripheral(pf_per));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
        int t;
        t = 0;
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 50);
        bready <= 1'b0;
        if (t >= 50) n_errors++;
        `CHK("bresp", er, bresp)
        // let an edge pass before the next request
        @(posedge aclk);
    endtask

    task automatic rd(input logic [9:0] i, input logic [7:0] ed, input logic [1:0] er);
        int t;
        t = 0;
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 50);
        rready <= 1'b0;
        if (t >= 50) n_errors++;
        `CHK("rdata", {24'h0, ed}, rdata)
        `CHK("rresp", er, rresp)
        // let an edge pass before the next request
        @(posedge aclk);
    endtask

    task automatic watch();
        w = 0;
        a = 0;
        c = 0;
        repeat (24) begin
            @(posedge aclk);
            w += (wake === 1'b1);
            a += (arr_clk === 1'b1);
            c += (cel_clk === 1'b1);
        end
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        pset = '0;
        pset.reset_pin_n = 1'b1;
        pset.addr_low = 8'h3C;
        pset.control_inputs = 3'h5;
        pset.ale = 1'b1;
        pset.high_byte_write_enable = 1'b1;
        pset.port_f_low_pins = 4'h6;
        pset.multiplexed_bus_upper_nibble = 4'h9;
        idle(6);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (RW_IDX[k]) rd(RW_IDX[k], 8'h00, OK);
        foreach (RW_IDX[k]) wr(RW_IDX[k], 8'hFF, OK);
        foreach (RW_IDX[k]) rd(RW_IDX[k], RW_BACK[k], OK);
        idle(4);
        `CHK("scan_en", 1'b1, scan_en)
        `CHK("page", 8'hFF, page)
        `CHK("auto_pd", 1'b1, auto_pd)
        `CHK("fast", 1'b0, fast)
        `CHK("pf_per", 1'b1, pf_per)
        `CHK("acc_off", 5'h00, acc)
        `CHK("feed_gated", 13'h0, feed)
        `CHK("cell_a", 8'hFF, cell_a)
        pset.mode_8051 <= 1'b1;
        idle(4);
        `CHK("acc_on", 5'h1F, acc)
        wr(`PMC_IDX_CELL_A, 8'h00, OK);
        rd(`PMC_IDX_CELL_A, 8'hFF, OK);
        wr(`PMC_IDX_MASK_A, 8'h0F, OK);
        wr(`PMC_IDX_CELL_A, 8'h00, OK);
        rd(`PMC_IDX_CELL_A, 8'h0F, OK);
        wr(`PMC_IDX_MASK_B, 8'hF0, OK);
        wr(`PMC_IDX_CELL_B, 8'h00, OK);
        rd(`PMC_IDX_CELL_B, 8'hF0, OK);
        idle(2);
        `CHK("cell_b", 8'hF0, cell_b)
        pset.map_strap <= 4'hA;
        pset.reset_pin_n <= 1'b0;
        idle(4);
        pset.reset_pin_n <= 1'b1;
        idle(4);
        rd(`PMC_IDX_MAP, 8'h14, OK);
        rd(`PMC_IDX_PSC0, 8'h3A, OK);
        rd(`PMC_IDX_PAGE, 8'h00, OK);
        `CHK("acc_map", 5'h14, acc)
        pset.imc <= 24'hC3A55A;
        pset.sector_lock <= 16'h1234;
        pset.boot_lock <= 4'h9;
        pset.security_set <= 1'b1;
        idle(4);
        wr(`PMC_IDX_IMC_A, 8'h00, OK);
        rd(`PMC_IDX_IMC_A, 8'h5A, OK);
        rd(`PMC_IDX_IMC_B, 8'hA5, OK);
        rd(`PMC_IDX_IMC_C, 8'hC3, OK);
        rd(`PMC_IDX_LOCK_LO, 8'h34, OK);
        rd(`PMC_IDX_LOCK_HI, 8'h12, OK);
        wr(`PMC_IDX_BOOT, 8'hFF, OK);
        rd(`PMC_IDX_BOOT, 8'h89, OK);
        wr(10'h3FF, 8'h55, ERR);
        rd(10'h3FF, 8'h00, ERR);
        wr(`PMC_IDX_PSC2, 8'h00, OK);
        idle(4);
        `CHK("feed_open", {8'h3C, 3'h5, 1'b1, 1'b1}, feed)
        pset.alt_bus_mode <= 1'b1;
        wr(`PMC_IDX_PSC2, 8'h04, OK);
        idle(4);
        `CHK("feed_alt", {8'h96, 3'h4, 1'b1, 1'b1}, feed)
        wr(`PMC_IDX_PSC0, 8'h08, OK);
        run_clk <= 1'b1;
        idle(3);
        watch();
        `CHK("wake_seen", 1'b1, w > 0)
        `CHK("arr_clk_seen", 1'b1, a > 0)
        `CHK("cel_clk_seen", 1'b1, c > 0)
        wr(`PMC_IDX_PSC0, 8'h18, OK);
        idle(3);
        watch();
        `CHK("wake_none", 0, w)
        `CHK("arr_clk_none", 0, a)
        `CHK("cel_clk_kept", 1'b1, c > 0)
        wr(`PMC_IDX_PSC0, 8'h20, OK);
        idle(3);
        watch();
        `CHK("wake_fast", 0, w)
        `CHK("arr_clk_kept", 1'b1, a > 0)
        `CHK("cel_clk_none", 0, c)
        `CHK("fast_on", 1'b1, fast)
        `CHK("auto_pd_off", 1'b0, auto_pd)
        run_clk <= 1'b0;
        idle(2);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        print_verdict();
    end
endmodule
